// file: src/ums_pkg.sv
// package for the one-hot mode selector
package ums_pkg;

    // ------------------------------------------------------------
    // clocking and timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DISC_MAX_MS = 10000;
    localparam int unsigned DISC_MAX_STEPS = DISC_MAX_MS / TICK_MS;
    localparam int unsigned DISC_W = 10;
    localparam int unsigned MAX_N = 8;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_DISC = 12'h004;
    localparam logic [11:0] ADDR_FPAT = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

    // ctrl fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_USE_FAULT_BIT = 1;

    // irq bits
    localparam int unsigned IRQ_FAULT_SET = 0;
    localparam int unsigned IRQ_FAULT_CLR = 1;
    localparam int unsigned IRQ_CHANGE = 2;
    localparam int unsigned IRQ_W = 3;

    // reset values
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [DISC_W-1:0] DISC_RST = 10'h000;
    localparam logic [MAX_N-1:0] FPAT_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        UMS_STOP = 3'b001,
        UMS_FIRST = 3'b010,
        UMS_RUN = 3'b100
    } ums_mode_type;

    typedef struct packed
    {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ums_apb_req_type;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ums_apb_rsp_type;

endpackage : ums_pkg

// file: src/ums_selector.sv
// one-hot mode selector with discrepancy timing, fault pattern and apb registers
`timescale 1ns/1ns

// How it works
// - one select input high drives the matching output high and all others low.
// - the width N is a parameter from two to eight, outputs equal to inputs.
// - with zero or several inputs high the last valid outputs are held during discrepancy.
// - an invalid combination lasting the full discrepancy time raises fault and fault pattern.
// - invalid inputs in the first cycle after stop-to-run fault at once.
// - discrepancy time is 0 to 10 s in 10 ms steps.
// - while faulted each output takes its bit of the configured fault pattern.
module ums_selector
    import ums_pkg::*;
#(
    parameter int unsigned N = 8,
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // apb slave
    input wire ums_apb_req_type apb_req,
    output ums_apb_rsp_type apb_rsp,
    // mode selection
    input wire logic [N-1:0] sel_in,
    output logic [N-1:0] sel_out,
    output logic fault_present,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        ums_mode_type mode;
        logic run;
        logic use_fault;
        logic [DISC_W-1:0] disc;
        logic [MAX_N-1:0] fpat;
        logic [31:0] tick_cnt;
        logic [DISC_W-1:0] steps;
        logic [N-1:0] last;
        logic [N-1:0] out;
        logic fault;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] imask;
        logic [31:0] prdata;
    } ums_state_type;

    ums_state_type st;
    ums_state_type next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic ums_one_hot(input logic [N-1:0] v);
        logic found;
        logic many;
        found = 1'b0;
        many = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            if (v[i])
            begin
                many = many | found;
                found = 1'b1;
            end
        end
        return found & ~many;
    endfunction : ums_one_hot

    logic valid;
    logic tick;
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic addr_ok;
    logic [N-1:0] fault_out;

    assign valid = ums_one_hot(sel_in);
    assign tick = (st.tick_cnt == TICK_LEN - 1);
    assign addr = apb_req.paddr[11:0];
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign fault_out = st.fpat[N-1:0];

    always_comb
    begin
        unique case (addr)
            ADDR_CTRL, ADDR_DISC, ADDR_FPAT, ADDR_STAT, ADDR_IRQ_STAT, ADDR_IRQ_MASK:
                addr_ok = (apb_req.paddr[31:12] == 20'h00000);
            default:
                addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] wclr;
        logic [DISC_W-1:0] dval;
        next_st = st;
        ev = '0;
        wclr = '0;
        dval = '0;

        // register writes
        if (wr && addr_ok)
        begin
            unique case (addr)
                ADDR_CTRL:
                begin
                    next_st.run = apb_req.pwdata[CTRL_RUN_BIT];
                    next_st.use_fault = apb_req.pwdata[CTRL_USE_FAULT_BIT];
                end
                ADDR_DISC:
                begin
                    dval = apb_req.pwdata[DISC_W-1:0];
                    // clamp to the 10 s ceiling
                    if (dval > DISC_W'(DISC_MAX_STEPS))
                        next_st.disc = DISC_W'(DISC_MAX_STEPS);
                    else
                        next_st.disc = dval;
                end
                ADDR_FPAT:
                    next_st.fpat = apb_req.pwdata[MAX_N-1:0];
                ADDR_IRQ_STAT:
                    wclr = apb_req.pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK:
                    next_st.imask = apb_req.pwdata[IRQ_W-1:0];
                default:
                    next_st.imask = st.imask;
            endcase
        end

        // 10 ms timebase
        if (tick)
            next_st.tick_cnt = '0;
        else
            next_st.tick_cnt = st.tick_cnt + 32'h1;

        unique case (st.mode)
            UMS_STOP:
            begin
                next_st.out = '0;
                next_st.fault = 1'b0;
                next_st.steps = '0;
                if (st.run)
                    next_st.mode = UMS_FIRST;
            end
            UMS_FIRST:
            begin
                next_st.mode = UMS_RUN;
                next_st.steps = '0;
                if (valid)
                begin
                    next_st.out = sel_in;
                    next_st.last = sel_in;
                end
                else
                begin
                    next_st.fault = 1'b1;
                    next_st.out = fault_out;
                    ev[IRQ_FAULT_SET] = 1'b1;
                end
            end
            UMS_RUN:
            begin
                if (valid)
                begin
                    next_st.steps = '0;
                    next_st.out = sel_in;
                    next_st.last = sel_in;
                    if (st.fault)
                    begin
                        next_st.fault = 1'b0;
                        ev[IRQ_FAULT_CLR] = 1'b1;
                    end
                    if (sel_in != st.last)
                        ev[IRQ_CHANGE] = 1'b1;
                end
                else if (st.fault)
                    next_st.out = fault_out;
                else if (st.steps >= st.disc)
                begin
                    next_st.fault = 1'b1;
                    next_st.out = fault_out;
                    ev[IRQ_FAULT_SET] = 1'b1;
                end
                else
                begin
                    next_st.out = st.last;
                    if (tick)
                        next_st.steps = st.steps + DISC_W'(1);
                end
                if (!st.run)
                    next_st.mode = UMS_STOP;
            end
            default:
                next_st.mode = UMS_STOP;
        endcase

        // sticky status, set beats clear
        next_st.istat = (st.istat & ~wclr) | ev;

        // read data captured in setup phase, unmapped reads give zero
        if (rd && !addr_ok)
            next_st.prdata = '0;
        else if (rd)
        begin
            unique case (addr)
                ADDR_CTRL:
                    next_st.prdata = {30'h0, st.use_fault, st.run};
                ADDR_DISC:
                    next_st.prdata = {22'h0, st.disc};
                ADDR_FPAT:
                    next_st.prdata = {24'h0, st.fpat};
                ADDR_STAT:
                    next_st.prdata = {MAX_N'(st.out), 5'h0, st.mode[2],
                        st.fault, st.run, 6'h0, st.steps};
                ADDR_IRQ_STAT:
                    next_st.prdata = {29'h0, st.istat};
                ADDR_IRQ_MASK:
                    next_st.prdata = {29'h0, st.imask};
                default:
                    next_st.prdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st.mode <= UMS_STOP;
            st.run <= CTRL_RST[CTRL_RUN_BIT];
            st.use_fault <= CTRL_RST[CTRL_USE_FAULT_BIT];
            st.disc <= DISC_RST;
            st.fpat <= FPAT_RST;
            st.tick_cnt <= '0;
            st.steps <= '0;
            st.last <= '0;
            st.out <= '0;
            st.fault <= 1'b0;
            st.istat <= '0;
            st.imask <= IRQ_MASK_RST;
            st.prdata <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sel_out = st.out;
    assign fault_present = st.fault & st.use_fault;
    assign irq = |(st.istat & st.imask);
    assign apb_rsp.prdata = st.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;

endmodule : ums_selector

// file: sim/ums_selector_asserts.sv
// port assertions for the one-hot mode selector
`timescale 1ns/1ns
module ums_selector_asserts
    import ums_pkg::*;
#(
    parameter int unsigned N = 8,
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // apb
    input wire ums_apb_req_type apb_req,
    input wire ums_apb_rsp_type apb_rsp,
    // selection
    input wire logic [N-1:0] sel_in,
    input wire logic [N-1:0] sel_out,
    input wire logic fault_present,
    input wire logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // steps
    // ----------------------------------------
    sequence s_valid_then_live;
        $onehot(sel_in) ##1 (sel_out != '0 && !fault_present);
    endsequence
    sequence s_access;
        apb_req.psel && apb_req.penable;
    endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ready_always: assert property (apb_rsp.pready == 1'b1)
        else $error("pready low");
    a_single_follows: assert property (s_valid_then_live |-> sel_out == $past(sel_in))
        else $error("output does not follow single input");
    a_hold_last: assert property ($onehot(sel_out) && !fault_present && !$onehot(sel_in)
        |=> fault_present || sel_out == '0 || $stable(sel_out))
        else $error("last output not held");
    a_fault_cause: assert property ($rose(fault_present) |-> !$onehot($past(sel_in)))
        else $error("fault without invalid input");
    a_fault_clears: assert property (fault_present && $onehot(sel_in) |=> !fault_present)
        else $error("fault not cleared");
    a_fault_stays: assert property (fault_present && !$onehot(sel_in)
        |=> fault_present || sel_out == '0)
        else $error("fault dropped while invalid");
    a_err_unmapped: assert property (apb_req.psel && apb_req.penable
        && apb_req.paddr[31:12] != '0
        |-> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    a_err_phase: assert property (apb_rsp.pslverr |-> s_access)
        else $error("error outside access phase");
endmodule : ums_selector_asserts

// file: sim/ums_partner.sv
// model of the select sources driving the selector
`timescale 1ns/1ns
module ums_partner
#(
    parameter int unsigned N = 8
)
(
    // clock
    input wire logic mclk,
    // wanted pattern from the bench
    input wire logic [N-1:0] want,
    // select lines
    output logic [N-1:0] sel_in
);
    initial sel_in = '0;
    // lines change just after an edge
    always @(posedge mclk)
        sel_in <= want;
endmodule : ums_partner

// file: sim/ums_selector_test.sv
// testbench for the one-hot mode selector
`timescale 1ns/1ns
module ums_selector_test;
    import ums_pkg::*;
    localparam int unsigned NS = 4;
    localparam int unsigned TL = 4;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ums_apb_req_type apb_req = '0;
    ums_apb_rsp_type apb_rsp;
    logic [NS-1:0] want = '0;
    logic [NS-1:0] sel_in;
    logic [NS-1:0] sel_out;
    logic fault_present;
    logic irq;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    ums_selector #(.N(NS), .TICK_LEN(TL)) ums_selector_i (.mclk(mclk), .resetn(resetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .sel_in(sel_in), .sel_out(sel_out),
        .fault_present(fault_present), .irq(irq));
    ums_partner #(.N(NS)) ums_partner_i (.mclk(mclk), .want(want), .sel_in(sel_in));

    initial
    begin
        forever #20 mclk = ~mclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        @(posedge mclk);
        while (apb_rsp.pready !== 1'b1)
            @(posedge mclk);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic wait_cy(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : wait_cy
    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rdchk(ADDR_CTRL, 32'h2);
        rdchk(ADDR_DISC, 32'h0);
        rdchk(ADDR_FPAT, 32'h0);
        rdchk(ADDR_IRQ_MASK, 32'h0);
        rdchk(32'h0000_1000, 32'h0);
        chk(32'(er), 32'h1);
        xfer(ADDR_FPAT, 1'b1, 32'ha);
        xfer(ADDR_DISC, 1'b1, 32'h2);
        xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
        xfer(ADDR_CTRL, 1'b1, 32'h3);
        wait_cy(3);
        chk(32'(sel_out), 32'ha);
        chk({30'h0, fault_present, irq}, 32'h3);
        for (int i = 0; i < NS; i++)
        begin
            want = NS'(1) << i;
            wait_cy(4);
            chk(32'(sel_out), 32'(want));
            chk(32'(fault_present), 32'h0);
        end
        chk(32'(irq), 32'h1);
        xfer(ADDR_IRQ_STAT, 1'b1, 32'h7);
        wait_cy(1);
        chk(32'(irq), 32'h0);
        xfer(ADDR_IRQ_MASK, 1'b1, 32'h0);
        want = 4'hc;
        wait_cy(4);
        chk(32'(sel_out), 32'h8);
        chk(32'(fault_present), 32'h0);
        n = 0;
        while (fault_present !== 1'b1 && n < 2 * TL + 2)
        begin
            wait_cy(1);
            n++;
        end
        chk({27'h0, fault_present, sel_out}, 32'h1a);
        chk(32'(irq), 32'h0);
        xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk(32'(rd[IRQ_FAULT_SET]), 32'h1);
        xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
        wait_cy(1);
        chk(32'(irq), 32'h1);
        xfer(ADDR_IRQ_STAT, 1'b1, 32'h1);
        wait_cy(1);
        chk(32'(irq), 32'h0);
        want = 4'h2;
        wait_cy(4);
        chk({27'h0, fault_present, sel_out}, 32'h2);
        xfer(ADDR_DISC, 1'b1, 32'h0);
        want = 4'h3;
        wait_cy(3);
        chk(32'(fault_present), 32'h1);
        rdchk(ADDR_STAT, 32'h0a070000);
        xfer(ADDR_DISC, 1'b1, 32'h3e8);
        rdchk(ADDR_DISC, 32'h3e8);
        xfer(ADDR_CTRL, 1'b1, 32'h2);
        wait_cy(2);
        chk({27'h0, fault_present, sel_out}, 32'h0);
        give_verdict();
    end
endmodule : ums_selector_test

bind ums_selector ums_selector_asserts #(.N(N), .TICK_LEN(TICK_LEN)) ums_selector_asserts_i (
    .mclk(mclk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sel_in(sel_in),
    .sel_out(sel_out), .fault_present(fault_present), .irq(irq));
